//--- verilog/scf_pkg.sv
// constants and types for the dual-role spi unit with fifos
// Notes on behaviour
// - writing one to a status bit clears it; writing zero leaves it.
// - an enabled fill or drain interrupt suppresses the matching dma request.
// - controller continuous select stays asserted after a frame until a command word.
// - peripheral continuous sends first frame, then echoes received bits through 32-bit shifter.
// - watermark values at or above fifo depth are truncated.
// - current transmit and receive fifo word counts are readable.
// - fixed transmit and receive fifo depths are readable.
// - software reset returns all registers except the fifo storage arrays to reset values.
// - enabling clears the module disable bit; disabling stops operation.
// - transmit and receive fifos flush independently.
// - a readable mode bit tells controller from peripheral.
// - every select output has its own polarity, all set together.
// - software chooses which select output the next transfer drives.
// - separate transmit and receive dma enables gate the dma requests.
// - data words serve as dma targets in both modes.
// - frames span 8 to 4096 bits, split into 32-bit words plus remainder.
// - a transmit data write pushes at once into the shared command/data fifo unless it is full, when the write is dropped.
package scf_pkg;
  localparam logic [12:0] FRAME_MIN_BITS = 13'h008;
  localparam logic [11:0] FRAME_MIN_M1   = 12'h007;
  localparam logic [12:0] WORD_MAX_BITS  = 13'h020;
  localparam logic [5:0]  WORD_BITS6     = 6'h20;
  localparam int          SCK_HALF_CYC   = 4;
  localparam int          ST_W           = 6;
  localparam int          ST_TDF         = 0;
  localparam int          ST_RDF         = 1;
  localparam int          ST_WCF         = 2;
  localparam int          ST_FCF         = 3;
  localparam int          ST_REF         = 4;
  localparam int          ST_TEF         = 5;
  localparam int          DMA_TX         = 0;
  localparam int          DMA_RX         = 1;
  localparam logic [5:0]  STATUS_RESET   = 6'h00;

  typedef enum logic [1:0] {
    SCF_IDLE  = 2'b00,
    SCF_SHIFT = 2'b01,
    SCF_LOAD  = 2'b11
  } scf_state_e;
endpackage : scf_pkg

//--- verilog/scf_spi_core.sv
// dual-role spi engine with transmit and receive fifos
`timescale 1ns/10ps
`default_nettype none
module scf_spi_core #(
  parameter int TX_DEPTH = 4,
  parameter int RX_DEPTH = 4,
  parameter int NPCS     = 4,
  parameter int SCK_HALF = scf_pkg::SCK_HALF_CYC
) (
  input  wire logic                         ref_clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         sw_reset_i,
  input  wire logic                         module_enable_bit_i,
  input  wire logic                         controller_mode_i,
  input  wire logic [NPCS-1:0]              pcs_polarity_i,
  input  wire logic [$clog2(NPCS)-1:0]      pcs_select_i,
  input  wire logic                         pcs_continuous_i,
  input  wire logic [11:0]                  frame_size_i,
  input  wire logic [7:0]                   tx_watermark_i,
  input  wire logic [7:0]                   rx_watermark_i,
  input  wire logic                         tx_flush_i,
  input  wire logic                         rx_flush_i,
  input  wire logic                         tx_valid_i,
  input  wire logic                         tx_is_cmd_i,
  input  wire logic [31:0]                  tx_data_i,
  input  wire logic                         rx_read_i,
  input  wire logic [scf_pkg::ST_W-1:0]     status_clear_i,
  input  wire logic [scf_pkg::ST_W-1:0]     int_enable_i,
  input  wire logic [1:0]                   dma_enable_i,
  input  wire logic                         sck_i,
  input  wire logic                         pcs_i,
  input  wire logic                         sdi_i,
  output logic [31:0]                       rx_data_o,
  output logic [$clog2(TX_DEPTH):0]         tx_count_o,
  output logic [$clog2(RX_DEPTH):0]         rx_count_o,
  output logic [7:0]                        tx_depth_o,
  output logic [7:0]                        rx_depth_o,
  output logic [scf_pkg::ST_W-1:0]          status_o,
  output logic                              irq_o,
  output logic                              tx_dma_req_o,
  output logic                              rx_dma_req_o,
  output logic                              mode_controller_o,
  output logic                              module_disable_bit_o,
  output logic                              sck_o,
  output logic                              sck_oe_o,
  output logic [NPCS-1:0]                   pcs_o,
  output logic                              pcs_oe_o,
  output logic                              sdo_o,
  output logic                              sdo_oe_o
);
  localparam int TXA = $clog2(TX_DEPTH);
  localparam int RXA = $clog2(RX_DEPTH);
  localparam int PW  = $clog2(NPCS);

  function automatic logic [31:0] word_mask(input logic [5:0] nbits);
    word_mask = (nbits == scf_pkg::WORD_BITS6) ? 32'hFFFFFFFF : ((32'h00000001 << nbits) - 32'h00000001);
  endfunction : word_mask

  function automatic logic [5:0] word_len(input logic [12:0] left);
    word_len = (left > scf_pkg::WORD_MAX_BITS) ? scf_pkg::WORD_BITS6 : left[5:0];
  endfunction : word_len

  logic                   srst;
  logic                   run;
  logic                   master_reg;
  logic [NPCS-1:0]        pol_reg;
  logic [PW-1:0]          sel_reg;
  logic [TXA-1:0]         tx_wm_reg;
  logic [RXA-1:0]         rx_wm_reg;
  logic [2:0]             sck_s;
  logic [2:0]             pcs_s;
  logic [1:0]             sdi_s;
  logic [32:0]            txm [TX_DEPTH];
  logic [31:0]            rxm [RX_DEPTH];
  logic [TXA-1:0]         tx_wr_reg;
  logic [TXA-1:0]         tx_rd_reg;
  logic [RXA-1:0]         rx_wr_reg;
  logic [RXA-1:0]         rx_rd_reg;
  scf_pkg::scf_state_e    st_reg;
  logic [31:0]            sh_reg;
  logic                   samp_reg;
  logic [5:0]             bit_cnt_reg;
  logic [12:0]            left_reg;
  logic [15:0]            div_reg;
  logic                   cs_on_reg;
  logic                   echo_reg;
  logic                   pcs_act;
  logic                   pcs_act_d;
  logic                   p_start;
  logic                   m_tick;
  logic                   rise;
  logic                   fall;
  logic                   word_end;
  logic                   frame_end;
  logic [5:0]             wb;
  logic [12:0]            flen;
  logic [12:0]            nxt_left;
  logic [5:0]             nxt_wb;
  logic [32:0]            tx_head;
  logic                   tx_data_avail;
  logic                   tx_push;
  logic                   tx_pop;
  logic                   rx_push;
  logic                   rx_pop;
  logic                   load_req;
  logic                   tef_set;
  logic                   ref_set;
  logic                   tdf_cond;
  logic                   rdf_cond;
  logic [31:0]            ld_word;
  logic [31:0]            rx_word;
  logic [scf_pkg::ST_W-1:0] st_set;

  assign srst = rst_i | sw_reset_i;
  assign run  = ~module_disable_bit_o;

  // mode and select polarity are captured only while disabled so a live write cannot upset a frame
  always_ff @(posedge ref_clk_i) begin
    if (srst) begin
      master_reg           <= 1'b0;
      pol_reg              <= '0;
      module_disable_bit_o <= 1'b1;
    end else begin
      module_disable_bit_o <= ~module_enable_bit_i;
      if (!module_enable_bit_i) begin
        master_reg <= controller_mode_i;
        pol_reg    <= pcs_polarity_i;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst) begin
      tx_wm_reg <= '0;
      rx_wm_reg <= '0;
    end else begin
      tx_wm_reg <= tx_watermark_i[TXA-1:0];
      rx_wm_reg <= rx_watermark_i[RXA-1:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst) begin
      sck_s <= '0;
      pcs_s <= '0;
      sdi_s <= '0;
    end else begin
      sck_s <= {sck_s[1:0], sck_i};
      pcs_s <= {pcs_s[1:0], pcs_i};
      sdi_s <= {sdi_s[0], sdi_i};
    end
  end

  assign pcs_act   = (pcs_s[1] == pol_reg[0]);
  assign pcs_act_d = (pcs_s[2] == pol_reg[0]);
  assign p_start   = pcs_act & ~pcs_act_d;
  assign m_tick    = (st_reg == scf_pkg::SCF_SHIFT) && (div_reg == 16'(SCK_HALF - 1));
  assign rise      = master_reg ? (m_tick & ~sck_o) : (sck_s[1] & ~sck_s[2]);
  assign fall      = master_reg ? (m_tick & sck_o) : (~sck_s[1] & sck_s[2]);
  assign wb        = word_len(left_reg);
  assign word_end  = run && (st_reg == scf_pkg::SCF_SHIFT) && fall && (bit_cnt_reg == wb - 6'h01);
  assign frame_end = word_end && (left_reg == {7'h00, wb});
  assign flen      = (frame_size_i < scf_pkg::FRAME_MIN_M1) ? scf_pkg::FRAME_MIN_BITS
                                                            : {1'b0, frame_size_i} + 13'h0001;
  assign nxt_left  = (st_reg == scf_pkg::SCF_LOAD) ? left_reg
                   : ((st_reg == scf_pkg::SCF_SHIFT && !frame_end) ? left_reg - {7'h00, wb} : flen);
  assign nxt_wb    = word_len(nxt_left);

  assign tx_head       = txm[tx_rd_reg];
  assign tx_data_avail = (tx_count_o != '0) && !tx_head[32];
  assign tx_push       = tx_valid_i && (tx_count_o != (TXA+1)'(TX_DEPTH));
  assign rx_word       = {sh_reg[30:0], samp_reg} & word_mask(wb);
  assign rx_push       = word_end && (rx_count_o != (RXA+1)'(RX_DEPTH));
  assign ref_set       = word_end && (rx_count_o == (RXA+1)'(RX_DEPTH));
  assign rx_pop        = rx_read_i && (rx_count_o != '0);

  always_comb begin
    load_req = 1'b0;
    case (st_reg)
      scf_pkg::SCF_IDLE:  load_req = run && (master_reg ? tx_data_avail : p_start);
      scf_pkg::SCF_SHIFT: load_req = word_end && !master_reg && !echo_reg && pcs_act
                                     && !(frame_end && pcs_continuous_i);
      scf_pkg::SCF_LOAD:  load_req = run && master_reg && tx_data_avail;
      default:            load_req = 1'b0;
    endcase
  end

  // a peripheral cannot stall the far clock, so a missing word goes out as zeros
  assign tef_set = load_req && !tx_data_avail && !master_reg;
  assign ld_word = tx_data_avail ? tx_head[31:0] : 32'h00000000;
  assign tx_pop  = (load_req && tx_data_avail)
                || (master_reg && run && st_reg == scf_pkg::SCF_IDLE && tx_count_o != '0 && tx_head[32]);

  always_ff @(posedge ref_clk_i) begin
    if (srst || tx_flush_i) begin
      tx_wr_reg  <= '0;
      tx_rd_reg  <= '0;
      tx_count_o <= '0;
    end else begin
      if (tx_push) begin
        txm[tx_wr_reg] <= {tx_is_cmd_i, tx_data_i};
        tx_wr_reg      <= tx_wr_reg + TXA'(1);
      end
      if (tx_pop) begin
        tx_rd_reg <= tx_rd_reg + TXA'(1);
      end
      tx_count_o <= tx_count_o + (TXA+1)'(tx_push) - (TXA+1)'(tx_pop);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst || rx_flush_i) begin
      rx_wr_reg  <= '0;
      rx_rd_reg  <= '0;
      rx_count_o <= '0;
    end else begin
      if (rx_push) begin
        rxm[rx_wr_reg] <= rx_word;
        rx_wr_reg      <= rx_wr_reg + RXA'(1);
      end
      if (rx_pop) begin
        rx_rd_reg <= rx_rd_reg + RXA'(1);
      end
      rx_count_o <= rx_count_o + (RXA+1)'(rx_push) - (RXA+1)'(rx_pop);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst) begin
      rx_data_o  <= 32'h00000000;
      tx_depth_o <= 8'h00;
      rx_depth_o <= 8'h00;
    end else begin
      rx_data_o  <= rxm[rx_rd_reg];
      tx_depth_o <= 8'(TX_DEPTH);
      rx_depth_o <= 8'(RX_DEPTH);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst) begin
      st_reg      <= scf_pkg::SCF_IDLE;
      sh_reg      <= 32'h00000000;
      samp_reg    <= 1'b0;
      bit_cnt_reg <= 6'h00;
      left_reg    <= scf_pkg::FRAME_MIN_BITS;
      div_reg     <= 16'h0000;
      sck_o       <= 1'b0;
      cs_on_reg   <= 1'b0;
      echo_reg    <= 1'b0;
      sel_reg     <= '0;
    end else if (!run) begin
      st_reg    <= scf_pkg::SCF_IDLE;
      sck_o     <= 1'b0;
      cs_on_reg <= 1'b0;
      echo_reg  <= 1'b0;
    end else begin
      div_reg <= (st_reg != scf_pkg::SCF_SHIFT || m_tick) ? 16'h0000 : div_reg + 16'h0001;
      if (m_tick) begin
        sck_o <= ~sck_o;
      end
      if (rise) begin
        samp_reg <= sdi_s[1];
      end
      if (load_req) begin
        sh_reg      <= ld_word << (6'h20 - nxt_wb);
        bit_cnt_reg <= 6'h00;
        left_reg    <= nxt_left;
        st_reg      <= scf_pkg::SCF_SHIFT;
        if (st_reg == scf_pkg::SCF_IDLE) begin
          echo_reg  <= 1'b0;
          cs_on_reg <= master_reg;
          sel_reg   <= pcs_select_i;
        end
      end else begin
        case (st_reg)
          scf_pkg::SCF_IDLE: begin
            if (master_reg && tx_pop) begin
              cs_on_reg <= 1'b0;
            end
          end
          scf_pkg::SCF_SHIFT: begin
            if (!master_reg && !pcs_act) begin
              st_reg <= scf_pkg::SCF_IDLE;
            end else if (word_end) begin
              bit_cnt_reg <= 6'h00;
              left_reg    <= nxt_left;
              if (master_reg) begin
                st_reg <= frame_end ? scf_pkg::SCF_IDLE : scf_pkg::SCF_LOAD;
                if (frame_end && !pcs_continuous_i) begin
                  cs_on_reg <= 1'b0;
                end
              end else begin
                // echo mode: the shifter keeps turning received bits back out
                sh_reg   <= {sh_reg[30:0], samp_reg};
                echo_reg <= 1'b1;
              end
            end else if (fall) begin
              sh_reg      <= {sh_reg[30:0], samp_reg};
              bit_cnt_reg <= bit_cnt_reg + 6'h01;
            end
          end
          scf_pkg::SCF_LOAD: st_reg <= scf_pkg::SCF_LOAD;
          default:           st_reg <= scf_pkg::SCF_IDLE;
        endcase
      end
    end
  end

  assign tdf_cond = (tx_count_o <= {1'b0, tx_wm_reg});
  assign rdf_cond = (rx_count_o > {1'b0, rx_wm_reg});

  always_comb begin
    st_set                  = '0;
    st_set[scf_pkg::ST_TDF] = tdf_cond;
    st_set[scf_pkg::ST_RDF] = rdf_cond;
    st_set[scf_pkg::ST_WCF] = word_end;
    st_set[scf_pkg::ST_FCF] = frame_end;
    st_set[scf_pkg::ST_REF] = ref_set;
    st_set[scf_pkg::ST_TEF] = tef_set;
  end

  // set wins over a same-cycle clear so no event is lost
  always_ff @(posedge ref_clk_i) begin
    if (srst) begin
      status_o <= scf_pkg::STATUS_RESET;
    end else begin
      status_o <= (status_o & ~status_clear_i) | st_set;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst) begin
      irq_o        <= 1'b0;
      tx_dma_req_o <= 1'b0;
      rx_dma_req_o <= 1'b0;
    end else begin
      irq_o        <= |(status_o & int_enable_i);
      tx_dma_req_o <= dma_enable_i[scf_pkg::DMA_TX] & ~int_enable_i[scf_pkg::ST_TDF] & tdf_cond;
      rx_dma_req_o <= dma_enable_i[scf_pkg::DMA_RX] & ~int_enable_i[scf_pkg::ST_RDF] & rdf_cond;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst) begin
      mode_controller_o <= 1'b0;
      sck_oe_o          <= 1'b0;
      pcs_oe_o          <= 1'b0;
      sdo_oe_o          <= 1'b0;
    end else begin
      mode_controller_o <= master_reg;
      sck_oe_o          <= run & master_reg;
      pcs_oe_o          <= run & master_reg;
      sdo_oe_o          <= run & (master_reg ? cs_on_reg : (pcs_act && st_reg == scf_pkg::SCF_SHIFT));
    end
  end

  assign sdo_o = sh_reg[31];

  genvar gi;
  generate
    for (gi = 0; gi < NPCS; gi++) begin : g_pcs
      always_ff @(posedge ref_clk_i) begin
        if (srst) begin
          pcs_o[gi] <= 1'b1;
        end else begin
          pcs_o[gi] <= (cs_on_reg && sel_reg == PW'(gi)) ? pol_reg[gi] : ~pol_reg[gi];
        end
      end
    end
  endgenerate
endmodule : scf_spi_core
`default_nettype wire

//--- testbench/scf_spi_core_props.sv
// concurrent checks on the spi unit ports
`timescale 1ns/10ps
`default_nettype none
module scf_spi_core_props #(
  parameter int TX_DEPTH = 4,
  parameter int RX_DEPTH = 4
) (
  input wire logic                     ref_clk_i,
  input wire logic                     rst_i,
  input wire logic                     sw_reset_i,
  input wire logic                     module_enable_bit_i,
  input wire logic [7:0]               tx_watermark_i,
  input wire logic [7:0]               rx_watermark_i,
  input wire logic                     tx_flush_i,
  input wire logic [5:0]               status_clear_i,
  input wire logic [5:0]               int_enable_i,
  input wire logic [1:0]               dma_enable_i,
  input wire logic [$clog2(TX_DEPTH):0] tx_count_o,
  input wire logic [$clog2(RX_DEPTH):0] rx_count_o,
  input wire logic [7:0]               tx_depth_o,
  input wire logic [7:0]               rx_depth_o,
  input wire logic [5:0]               status_o,
  input wire logic                     irq_o,
  input wire logic                     tx_dma_req_o,
  input wire logic                     rx_dma_req_o,
  input wire logic                     module_disable_bit_o
);
  logic [1:0] settle_reg;
  logic       ok;
  logic       rdf_cond;
  logic       tdf_cond;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i || sw_reset_i);
  // past values straddling a reset are not trusted
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || sw_reset_i) settle_reg <= 2'h0;
    else if (settle_reg != 2'h3) settle_reg <= settle_reg + 2'h1;
  end
  assign ok = (settle_reg == 2'h3);
  assign rdf_cond = ok && (rx_count_o > (rx_watermark_i % RX_DEPTH));
  assign tdf_cond = ok && !module_disable_bit_o && (tx_count_o <= (tx_watermark_i % TX_DEPTH));
  property p_disable; ok |-> module_disable_bit_o == !$past(module_enable_bit_i); endproperty
  a_disable: assert property (p_disable) else $error("disable bit wrong");
  property p_irq; ok |-> irq_o == |$past(status_o & int_enable_i); endproperty
  a_irq: assert property (p_irq) else $error("irq wrong");
  property p_tx_dma; ok && tx_dma_req_o |-> $past(dma_enable_i[0] && !int_enable_i[0]); endproperty
  a_tx_dma: assert property (p_tx_dma) else $error("tx dma not gated");
  property p_rx_dma; ok && rx_dma_req_o |-> $past(dma_enable_i[1] && !int_enable_i[1]); endproperty
  a_rx_dma: assert property (p_rx_dma) else $error("rx dma not suppressed");
  property p_fcf_hold; ok && $past(status_o[3]) && !$past(status_clear_i[3]) |-> status_o[3]; endproperty
  a_fcf_hold: assert property (p_fcf_hold) else $error("flag lost");
  property p_rdf; rdf_cond [*4] |-> status_o[1]; endproperty
  a_rdf: assert property (p_rdf) else $error("rx ready missing");
  property p_tdf; tdf_cond [*4] |-> status_o[0]; endproperty
  a_tdf: assert property (p_tdf) else $error("tx request missing");
  property p_depth; ok |-> tx_depth_o == TX_DEPTH && rx_depth_o == RX_DEPTH; endproperty
  a_depth: assert property (p_depth) else $error("depth wrong");
  property p_count; tx_count_o <= TX_DEPTH && rx_count_o <= RX_DEPTH; endproperty
  a_count: assert property (p_count) else $error("count out of range");
  property p_flush; ok && $past(tx_flush_i) |-> tx_count_o == 0; endproperty
  a_flush: assert property (p_flush) else $error("flush left words");
endmodule : scf_spi_core_props
bind scf_spi_core scf_spi_core_props #(.TX_DEPTH(TX_DEPTH), .RX_DEPTH(RX_DEPTH)) u_props (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sw_reset_i(sw_reset_i), .module_enable_bit_i(module_enable_bit_i),
  .tx_watermark_i(tx_watermark_i), .rx_watermark_i(rx_watermark_i), .tx_flush_i(tx_flush_i),
  .status_clear_i(status_clear_i), .int_enable_i(int_enable_i), .dma_enable_i(dma_enable_i),
  .tx_count_o(tx_count_o), .rx_count_o(rx_count_o), .tx_depth_o(tx_depth_o), .rx_depth_o(rx_depth_o),
  .status_o(status_o), .irq_o(irq_o), .tx_dma_req_o(tx_dma_req_o), .rx_dma_req_o(rx_dma_req_o),
  .module_disable_bit_o(module_disable_bit_o));
`default_nettype wire

//--- testbench/scf_periph_model.sv
// spi peripheral on the far side of controller frames
`timescale 1ns/10ps
`default_nettype none
module scf_periph_model (
  input  wire logic       sck_i,
  input  wire logic       cs_n_i,
  input  wire logic       mosi_i,
  input  wire logic [7:0] reply_i,
  output logic            miso_o,
  output logic [7:0]      seen_o
);
  logic [7:0] sh_reg;
  initial begin
    miso_o = 1'b0;
    seen_o = 8'h00;
    sh_reg = 8'h00;
  end
  // first bit must stand before the first rising edge
  always @(negedge cs_n_i) begin
    sh_reg = reply_i;
    miso_o = reply_i[7];
  end
  // released line inverts so a stale bit cannot pass
  always @(posedge cs_n_i) miso_o = ~miso_o;
  always @(posedge sck_i) if (!cs_n_i) seen_o = {seen_o[6:0], mosi_i};
  always @(negedge sck_i) begin
    if (!cs_n_i) begin
      sh_reg = {sh_reg[6:0], 1'b0};
      miso_o = sh_reg[7];
    end
  end
endmodule : scf_periph_model
`default_nettype wire

//--- testbench/scf_spi_core_tb.sv
// self-checking bench for the spi unit
`timescale 1ns/10ps
`default_nettype none
module scf_spi_core_tb;
  logic        clk, rst, swr, en, ctrl, cont, txv, txc, rxr, txf, rxf, bsck, bpcs, bsdi, sdi;
  logic [1:0]  sel, dma;
  logic [7:0]  rwm, seen;
  logic [31:0] txd, rxd;
  logic [2:0]  txn, rxn;
  logic [7:0]  txdep, rxdep;
  logic [5:0]  clr, ien, st;
  logic        irq, transmit_data_register, receive_data_register, mc, dis, sck, sdo, miso, soe, poe, doe;
  logic [3:0]  pcs, pol;
  logic [15:0] psdo;
  int          fail_count, samples_checked;
  assign sdi = ctrl ? miso : bsdi;
  scf_spi_core dut (.ref_clk_i(clk), .rst_i(rst), .sw_reset_i(swr), .module_enable_bit_i(en),
    .controller_mode_i(ctrl), .pcs_polarity_i(pol), .pcs_select_i(sel), .pcs_continuous_i(cont),
    .frame_size_i(12'h007), .tx_watermark_i(8'h04), .rx_watermark_i(rwm), .tx_flush_i(txf),
    .rx_flush_i(rxf), .tx_valid_i(txv), .tx_is_cmd_i(txc), .tx_data_i(txd), .rx_read_i(rxr),
    .status_clear_i(clr), .int_enable_i(ien), .dma_enable_i(dma), .sck_i(bsck), .pcs_i(bpcs),
    .sdi_i(sdi), .rx_data_o(rxd), .tx_count_o(txn), .rx_count_o(rxn), .tx_depth_o(txdep),
    .rx_depth_o(rxdep), .status_o(st), .irq_o(irq), .tx_dma_req_o(transmit_data_register), .rx_dma_req_o(receive_data_register),
    .mode_controller_o(mc), .module_disable_bit_o(dis), .sck_o(sck), .sck_oe_o(soe), .pcs_o(pcs),
    .pcs_oe_o(poe), .sdo_o(sdo), .sdo_oe_o(doe));
  scf_periph_model u_model (.sck_i(sck), .cs_n_i(pcs[0]), .mosi_i(sdo), .reply_i(8'h3C),
    .miso_o(miso), .seen_o(seen));
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic push(input logic [31:0] d, input logic c);
    @(posedge clk);
    txv <= 1'b1;
    txc <= c;
    txd <= d;
    @(posedge clk);
    txv <= 1'b0;
  endtask : push
  // far controller: bits msb first, sdo taken just before each rising link edge
  task automatic pframe(input logic [15:0] d, input int n);
    bpcs = 1'b0;
    #200;
    for (int i = n - 1; i >= 0; i--) begin
      bsdi = d[i];
      #40 psdo = {psdo[14:0], sdo};
      bsck = 1'b1;
      #40 bsck = 1'b0;
    end
    #100 bpcs = 1'b1;
  endtask : pframe
  task automatic wait_rx;
    int k = 0;
    while (rxn === 3'h0 && k < 2000) begin
      step(1);
      k++;
    end
    step(2);
    chk(k < 2000, 1);
  endtask : wait_rx
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #100000;
    fail_count++;
    print_verdict;
  end
  initial begin
    {rst, ctrl, bpcs} = 3'b111;
    {swr, en, cont, txv, txc, rxr, txf, rxf, bsck, bsdi} = '0;
    {sel, dma, clr, ien, txd, pol} = '0;
    rwm = 8'h04;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    step(2);
    chk(dis, 1);
    chk(pcs, 4'hF);
    chk({txdep, rxdep}, 16'h0404);
    $display("test reset done");
    repeat (5) push(32'h0000_00F0, 1'b0);
    step(2);
    chk(txn, 3'h4);
    @(posedge clk) rxf <= 1'b1;
    @(posedge clk) rxf <= 1'b0;
    step(1);
    chk(txn, 3'h4);
    @(posedge clk) txf <= 1'b1;
    @(posedge clk) txf <= 1'b0;
    step(1);
    chk(txn, 3'h0);
    $display("test fill done");
    @(posedge clk) en <= 1'b1;
    step(2);
    chk({dis, mc, soe, poe}, 4'b0111);
    push(32'h0000_00A5, 1'b0);
    wait_rx;
    chk(rxd, 32'h3C);
    chk(seen, 8'hA5);
    chk(st[3:1], 3'b111);
    chk(pcs[0], 1);
    @(posedge clk) clr <= 6'h08;
    @(posedge clk) clr <= 6'h00;
    step(1);
    chk(st[3:1], 3'b011);
    @(posedge clk) dma <= 2'b10;
    step(3);
    chk({transmit_data_register, receive_data_register, irq}, 3'b010);
    @(posedge clk) {ien, dma} <= {6'h02, 2'b11};
    step(3);
    chk({transmit_data_register, receive_data_register, irq}, 3'b101);
    @(posedge clk) rxr <= 1'b1;
    @(posedge clk) rxr <= 1'b0;
    step(3);
    chk(rxn, 3'h0);
    ien <= 6'h00;
    $display("test frame done");
    sel <= 2'h2;
    push(32'h0000_005A, 1'b0);
    step(8);
    chk(pcs, 4'hB);
    wait_rx;
    sel <= 2'h0;
    cont <= 1'b1;
    push(32'h0000_0011, 1'b0);
    step(100);
    chk({pcs[0], doe}, 2'b01);
    push(32'h0, 1'b1);
    step(8);
    chk({pcs[0], doe}, 2'b10);
    $display("test select done");
    @(posedge clk) swr <= 1'b1;
    @(posedge clk) swr <= 1'b0;
    step(2);
    chk({mc, rxn, st[3]}, 5'h00);
    $display("test soft reset done");
    en <= 1'b0;
    step(2);
    {ctrl, cont, pol} <= {2'b00, 4'h4};
    step(3);
    chk(pcs, 4'hB);
    en <= 1'b1;
    step(3);
    pframe(16'h00C3, 8);
    wait_rx;
    chk(rxd, 32'h0000_00C3);
    chk({mc, soe, poe}, 3'b000);
    $display("test peripheral done");
    cont <= 1'b1;
    push(32'h0000_0096, 1'b0);
    push(32'h0000_0077, 1'b0);
    step(2);
    pframe(16'hC35A, 16);
    step(4);
    chk(psdo, 16'h9600);
    chk({txn, rxn}, 6'h0B);
    $display("test echo done");
    print_verdict;
  end
endmodule : scf_spi_core_tb
`default_nettype wire
